//--- core/wm_dispatch_pkg.sv
`default_nettype none
package wm_dispatch_pkg;
	// ==========================================================
	// Wishbone register map
	localparam logic [3:0] ADDR_CMD = 4'h0;
	localparam logic [3:0] ADDR_ZW_MODE = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_KERNEL_SEL = 4'hC;
	// ==========================================================
	// Command word field positions
	localparam int BIT_RSVD24 = 24;
	localparam int BIT_LEGACY_LINE = 23;
	localparam int BIT_DISCARD = 22;
	localparam int BIT_COMP_DEPTH = 21;
	localparam int BIT_SRC_DEPTH = 20;
	localparam int BIT_DISPATCH = 19;
	localparam int BIT_RSVD18 = 18;
	localparam int POS_ENDCAP = 16;
	localparam int POS_LINE_AA = 14;
	localparam int BIT_WIDE32 = 2;
	localparam int BIT_WIDE16 = 1;
	localparam int BIT_WIDE8 = 0;
	localparam logic [31:0] CMD_RESET = 32'h0000_0000;
	// ==========================================================
	// Z/W interpolation mode encodings
	localparam logic [1:0] ZW_PIXEL = 2'h0;
	localparam logic [1:0] ZW_RSVD = 2'h1;
	localparam logic [1:0] ZW_CENTROID = 2'h2;
	localparam logic [1:0] ZW_SAMPLE = 2'h3;
	// AA widths in quarter pixels: 0.5, 1.0, 2.0, 4.0
	localparam logic [4:0] AA_Q0 = 5'h02;
	localparam logic [4:0] AA_Q1 = 5'h04;
	localparam logic [4:0] AA_Q2 = 5'h08;
	localparam logic [4:0] AA_Q3 = 5'h10;
	// ==========================================================
	typedef enum logic [1:0] {
		interp_at_pixel,
		interp_at_centroid,
		interp_at_sample,
		interp_reserved
	} zw_interp_type;

	typedef struct packed {
		logic legacy_line;
		logic discard_capable;
		logic computed_depth;
		logic source_depth;
		logic thread_dispatch;
		logic [4:0] endcap_qpix;
		logic [4:0] line_aa_qpix;
		logic [2:0] width_enables;
		zw_interp_type zw_mode;
	} wm_config_type;

	typedef struct packed {
		wm_config_type cfg;
		logic [31:0] cmd_raw;
		logic [1:0] zw_raw;
		logic [1:0] kernel_sel;
		logic [3:0] status;
		logic cmd_count_tgl;
		logic ack;
		logic [31:0] rdata;
	} wm_state_type;
endpackage
`default_nettype wire

//--- core/windower_pixel_dispatch_config.sv
`default_nettype none
module windower_pixel_dispatch_config (
	input wire logic clk_i, // Core clock
	input wire logic rst_i, // Sync reset, high
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Write enable
	input wire logic [3:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte lanes
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	output logic legacy_line_o, // Diamond line rules
	output logic discard_capable_o, // Shader may discard
	output logic computed_depth_o, // Shader writes depth
	output logic payload_src_depth_o, // Source depth in payload
	output logic [1:0] src_depth_interp_o, // Interp of payload depth
	output logic dispatch_allowed_o, // Threads may launch
	output logic [4:0] endcap_qpix_o, // End cap width, quarter px
	output logic [4:0] line_aa_qpix_o, // Line AA width, quarter px
	output logic [2:0] width_enables_o, // 32/16/8 dispatch enables
	output logic wide32_pack_o, // Eight subspans per payload
	output logic [1:0] kernel_sel_o // Kernel slot for pointer and count
);
	wm_dispatch_pkg::wm_state_type s_q, s_d;

	function automatic logic [4:0] aa_width(input logic [1:0] code);
		case (code)
			2'h0: aa_width = wm_dispatch_pkg::AA_Q0;
			2'h1: aa_width = wm_dispatch_pkg::AA_Q1;
			2'h2: aa_width = wm_dispatch_pkg::AA_Q2;
			default: aa_width = wm_dispatch_pkg::AA_Q3;
		endcase
	endfunction

	function automatic wm_dispatch_pkg::zw_interp_type zw_decode(input logic [1:0] code);
		case (code)
			wm_dispatch_pkg::ZW_PIXEL: zw_decode = wm_dispatch_pkg::interp_at_pixel;
			wm_dispatch_pkg::ZW_CENTROID: zw_decode = wm_dispatch_pkg::interp_at_centroid;
			wm_dispatch_pkg::ZW_SAMPLE: zw_decode = wm_dispatch_pkg::interp_at_sample;
			default: zw_decode = wm_dispatch_pkg::interp_reserved;
		endcase
	endfunction

	// Lane-merged write data
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	// Widths not in the supported set, used only to flag misuse
	function automatic logic combo_bad(input logic [2:0] en);
		combo_bad = (en == 3'h0) || (en == 3'h4) || (en == 3'h6);
	endfunction

	// ==========================================================
	// Decode and hold
	always_comb begin
		logic [31:0] w;
		logic hit;
		w = '0;
		s_d = s_q;
		hit = wb_cyc_i && wb_stb_i && !s_q.ack;
		s_d.ack = hit;
		s_d.rdata = '0;
		if (hit && wb_we_i) begin
			case (wb_adr_i)
				wm_dispatch_pkg::ADDR_CMD: begin
					// Selected byte lanes merged into the held word; fields stay until next command
					w = merge(s_q.cmd_raw, wb_dat_i, wb_sel_i);
					s_d.cmd_raw = w;
					s_d.cmd_count_tgl = !s_q.cmd_count_tgl;
					s_d.cfg.legacy_line = w[wm_dispatch_pkg::BIT_LEGACY_LINE];
					s_d.cfg.discard_capable = w[wm_dispatch_pkg::BIT_DISCARD];
					s_d.cfg.computed_depth = w[wm_dispatch_pkg::BIT_COMP_DEPTH];
					s_d.cfg.source_depth = w[wm_dispatch_pkg::BIT_SRC_DEPTH];
					s_d.cfg.thread_dispatch = w[wm_dispatch_pkg::BIT_DISPATCH];
					s_d.cfg.endcap_qpix = aa_width(w[wm_dispatch_pkg::POS_ENDCAP +: 2]);
					s_d.cfg.line_aa_qpix = aa_width(w[wm_dispatch_pkg::POS_LINE_AA +: 2]);
					s_d.cfg.width_enables = w[wm_dispatch_pkg::BIT_WIDE8 +: 3];
					// Sticky misuse flags: reserved bits, kill without dispatch, bad combo
					s_d.status[0] = s_q.status[0] | w[wm_dispatch_pkg::BIT_RSVD24]
						| w[wm_dispatch_pkg::BIT_RSVD18];
					s_d.status[1] = s_q.status[1] | (w[wm_dispatch_pkg::BIT_DISCARD]
						& !w[wm_dispatch_pkg::BIT_DISPATCH]);
					s_d.status[2] = s_q.status[2] | combo_bad(w[wm_dispatch_pkg::BIT_WIDE8 +: 3]);
				end
				wm_dispatch_pkg::ADDR_ZW_MODE: begin
					if (wb_sel_i[0]) begin
						s_d.zw_raw = wb_dat_i[1:0];
						s_d.cfg.zw_mode = zw_decode(wb_dat_i[1:0]);
						s_d.status[3] = s_q.status[3] | (wb_dat_i[1:0] == wm_dispatch_pkg::ZW_RSVD);
					end
				end
				wm_dispatch_pkg::ADDR_STATUS: begin
					if (wb_sel_i[0]) begin
						s_d.status = s_q.status & ~wb_dat_i[3:0];
					end
				end
				wm_dispatch_pkg::ADDR_KERNEL_SEL: begin
					if (wb_sel_i[0]) begin
						s_d.kernel_sel = wb_dat_i[1:0];
					end
				end
				default: begin
				end
			endcase
		end else if (hit) begin
			case (wb_adr_i)
				wm_dispatch_pkg::ADDR_CMD: s_d.rdata = s_q.cmd_raw;
				wm_dispatch_pkg::ADDR_ZW_MODE: s_d.rdata = {30'h0, s_q.zw_raw};
				wm_dispatch_pkg::ADDR_STATUS: s_d.rdata = {27'h0, s_q.cmd_count_tgl, s_q.status};
				wm_dispatch_pkg::ADDR_KERNEL_SEL: s_d.rdata = {30'h0, s_q.kernel_sel};
				default: s_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs, each straight from state
	assign wb_ack_o = s_q.ack;
	assign wb_dat_o = s_q.rdata;
	assign legacy_line_o = s_q.cfg.legacy_line;
	assign discard_capable_o = s_q.cfg.discard_capable;
	assign computed_depth_o = s_q.cfg.computed_depth;
	assign payload_src_depth_o = s_q.cfg.source_depth;
	assign src_depth_interp_o = s_q.zw_raw;
	assign dispatch_allowed_o = s_q.cfg.thread_dispatch;
	assign endcap_qpix_o = s_q.cfg.endcap_qpix;
	assign line_aa_qpix_o = s_q.cfg.line_aa_qpix;
	assign width_enables_o = s_q.cfg.width_enables;
	assign wide32_pack_o = s_q.cfg.width_enables[wm_dispatch_pkg::BIT_WIDE32];
	assign kernel_sel_o = s_q.kernel_sel;
endmodule // windower_pixel_dispatch_config
`default_nettype wire

//--- tb/wm_cfg_chk.sv
`default_nettype none
module wm_cfg_chk (
	input wire logic clk_i, // In
	input wire logic rst_i, // In
	input wire logic wb_cyc_i, // In
	input wire logic wb_stb_i, // In
	input wire logic wb_we_i, // In
	input wire logic [3:0] wb_adr_i, // In
	input wire logic [3:0] wb_sel_i, // In
	input wire logic [31:0] wb_dat_i, // In
	input wire logic wb_ack_o, // In
	input wire logic legacy_line_o, // In
	input wire logic discard_capable_o, // In
	input wire logic computed_depth_o, // In
	input wire logic payload_src_depth_o, // In
	input wire logic [1:0] src_depth_interp_o, // In
	input wire logic dispatch_allowed_o, // In
	input wire logic [4:0] endcap_qpix_o, // In
	input wire logic [4:0] line_aa_qpix_o, // In
	input wire logic [2:0] width_enables_o, // In
	input wire logic wide32_pack_o // In
);
	timeunit 1ns;
	timeprecision 100ps;
	logic tk;
	logic wr;
	assign tk = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o;
	assign wr = tk & wb_adr_i == 4'h0 & wb_sel_i == 4'hf;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// =========
	AST_LEGACY: assert property (wr |=> legacy_line_o == $past(wb_dat_i[23])) else $error("legacy");
	AST_FLAGS: assert property (wr |=> {discard_capable_o, computed_depth_o, payload_src_depth_o}
		== $past(wb_dat_i[22:20])) else $error("flags");
	AST_DISP: assert property (wr |=> dispatch_allowed_o == $past(wb_dat_i[19])) else $error("disp");
	AST_ENDCAP: assert property (wr |=> endcap_qpix_o == 5'h02 << $past(wb_dat_i[17:16])) else $error("cap");
	AST_LINEAA: assert property (wr |=> line_aa_qpix_o == 5'h02 << $past(wb_dat_i[15:14])) else $error("aa");
	AST_WIDE: assert property (wr |=> wide32_pack_o == $past(wb_dat_i[2])
		&& width_enables_o == $past(wb_dat_i[2:0])) else $error("w");
	AST_HOLD: assert property (!(tk && wb_adr_i == 4'h0) |=> $stable({legacy_line_o, endcap_qpix_o,
		width_enables_o})) else $error("hold");
	AST_ZW: assert property (tk && wb_adr_i == 4'h4 && wb_sel_i[0] |=> src_depth_interp_o ==
		$past(wb_dat_i[1:0])) else $error("zw");
	cover property (wr && wb_dat_i[23]);
	cover property (wr && !wb_dat_i[19]);
	cover property (tk && wb_adr_i == 4'h4);
endmodule // wm_cfg_chk
bind windower_pixel_dispatch_config wm_cfg_chk u_chk (.*);
`default_nettype wire

//--- tb/ps_kernel_model.sv
`default_nettype none
module ps_kernel_model (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic px_i, // Pixel work waiting
	input wire logic dispatch_allowed_i, // Launch gate
	output logic [7:0] launches_o // Threads started
);
	timeunit 1ns;
	timeprecision 100ps;
	// A kernel that is never launched writes no colour or depth
	always_ff @(posedge clk_i) begin
		if (rst_i) launches_o <= 8'h00;
		else if (px_i && dispatch_allowed_i) launches_o <= launches_o + 8'h01;
	end
endmodule // ps_kernel_model
`default_nettype wire

//--- tb/windower_pixel_dispatch_config_test.sv
`default_nettype none
module windower_pixel_dispatch_config_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, px = 0, ack, ll, dc, cd, sd, da, wp;
	logic [3:0] adr = 4'h0, sel = 4'hf, bsel = 4'hf;
	logic [31:0] dat = 32'h0000_0000, rd, w, dat_o;
	logic [1:0] zi, ks;
	logic [4:0] ec, la;
	logic [2:0] wen;
	logic [7:0] ln;
	logic [18:0] seen;
	int failures = 0, n_tests = 0, cyc_n = 0, seed = 32'he2b8, i;
	assign seen = {ll, dc, cd, sd, da, ec, la, wen, wp};
	always #2.5 clk_i = ~clk_i;
	windower_pixel_dispatch_config dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.legacy_line_o(ll), .discard_capable_o(dc), .computed_depth_o(cd), .payload_src_depth_o(sd),
		.src_depth_interp_o(zi), .dispatch_allowed_o(da), .endcap_qpix_o(ec), .line_aa_qpix_o(la),
		.width_enables_o(wen), .wide32_pack_o(wp), .kernel_sel_o(ks));
	ps_kernel_model pk (.clk_i(clk_i), .rst_i(rst_i), .px_i(px), .dispatch_allowed_i(da), .launches_o(ln));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	// Holds the request until ack is seen at an edge, then idles one cycle
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		{cyc, stb, we, adr, sel, dat} <= {2'b11, wr, a, bsel, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dat_o;
		{cyc, stb} <= 2'b00;
		@(posedge clk_i);
	endtask
	function automatic logic [18:0] ex(input logic [31:0] c);
		return {c[23:19], 5'h02 << c[17:16], 5'h02 << c[15:14], c[2:0], c[2]};
	endfunction
	task final_report;
		if (failures == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			failures++;
			final_report;
		end
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk(seen, 0);
		for (i = 0; i < 16; i++) begin
			// Kill, depth buffer and surface format cases live outside the block: no reserved bit, kill without dispatch or bad width combo is drawn
			w = $random(seed) & 32'h00fb_c007;
			if (!w[19]) w[22] = 0;
			if (w[2:0] != 3'h2) w[0] = 1;
			bus(1, 4'h0, w);
			chk(seen, ex(w));
			bus(0, 4'h0, 0);
			chk(rd, w);
		end
		// One lane only: the other lanes of the command word must survive
		bsel = 4'h4;
		bus(1, 4'h0, 32'hff28_ffff);
		bsel = 4'hf;
		w = {w[31:24], 8'h28, w[15:0]};
		chk(seen, ex(w));
		bus(0, 4'h0, 0);
		chk(rd, w);
		for (i = 0; i < 4; i++) begin
			if (i != 1) bus(1, 4'h4, i);
			if (i != 1) chk(zi, i & 3);
			bus(1, 4'hc, i);
			chk(ks, i & 3);
		end
		bus(0, 4'h2, 32'hffff_ffff);
		chk(rd, 0);
		bus(1, 4'h8, 32'h0000_000f);
		bus(1, 4'h0, 32'h0100_0000);
		bus(0, 4'h8, 0);
		chk(rd[3:0], 4'h5);
		w = ln;
		px <= 1;
		repeat (8) @(posedge clk_i);
		chk(ln, w);
		bus(1, 4'h0, 32'h0008_0001);
		repeat (4) @(posedge clk_i);
		chk(ln, w + 5);
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk(seen, 0);
		chk(ln, 0);
		bus(1, 4'h0, 32'h0088_4001);
		chk(seen, ex(32'h0088_4001));
		final_report;
	end
endmodule // windower_pixel_dispatch_config_test
`default_nettype wire
